//--- bench/dps_master_model.sv
`timescale 1ns/1ps
// ************************************
// Motion master command source
// ************************************
module dps_master_model (
  input wire i_clk,
  input wire [15:0] i_req_cmd,
  input wire [3:0] i_state_code,
  output wire [15:0] o_cmd
);
  reg [3:0] last_reg = 4'h0;
  reg hold_reg = 1'b0;
  // Drop fault reset once the device has left the fault state
  always @(posedge i_clk)
  begin
    last_reg <= i_state_code;
    if (last_reg == 4'h7 && i_state_code != 4'h7)
      hold_reg <= 1'b1;
    else if (!i_req_cmd[7])
      hold_reg <= 1'b0;
  end
  assign o_cmd = {i_req_cmd[15:8], i_req_cmd[7] & ~hold_reg, i_req_cmd[6:0]};
endmodule

//--- bench/dps_sm_monitor.sv
`timescale 1ns/1ps
// ************************************
// Power state checker
// ************************************
module dps_sm_monitor (
  input wire i_clk,
  input wire i_rst,
  input wire [15:0] i_cmd,
  input wire i_enable_in,
  input wire [7:0] i_err_set,
  input wire [7:0] i_err_active,
  input wire i_fatal,
  input wire [3:0] o_state_code,
  input wire o_power_en,
  input wire o_motion_en,
  input wire o_setpoint_en,
  input wire o_setpoint_clr,
  input wire [7:0] o_err_flags
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // No fault source present
  wire calm = (i_err_set == 8'h00) && !i_fatal;
  sequence s_swon_to_op;
    (o_state_code == 4'h3) ##1 (o_state_code == 4'h4);
  endsequence
  sequence s_react_to_fault;
    (o_state_code == 4'h6) ##1 (o_state_code == 4'h7);
  endsequence
  property p_init;
    $fell(i_rst) |-> ##[1:40] (o_state_code == 4'h1);
  endproperty
  property p_shutdown;
    (o_state_code == 4'h1 && i_cmd[3:0] == 4'h6 && calm) |=> (o_state_code == 4'h2);
  endproperty
  property p_switch_on;
    (o_state_code == 4'h2 && i_cmd[3:0] == 4'h7 && $past(i_enable_in, 2) && calm)
      |=> (o_state_code == 4'h3 && o_power_en);
  endproperty
  property p_enable_op;
    s_swon_to_op |-> (o_setpoint_clr && o_motion_en) ##1 !o_setpoint_clr;
  endproperty
  property p_qstop;
    (o_state_code == 4'h4 && i_cmd[3:0] == 4'hb && calm) |=> (o_state_code == 4'h5 && o_power_en);
  endproperty
  property p_fault_entry;
    (o_state_code >= 4'h1 && o_state_code <= 4'h5 && i_err_set != 8'h00 && !i_fatal)
      |=> (o_state_code == 4'h6);
  endproperty
  property p_fault_off;
    s_react_to_fault |-> (!o_power_en && !o_motion_en);
  endproperty
  property p_hold_fault;
    (o_state_code == 4'h7 && (o_err_flags & i_err_active) != 8'h00) |=> (o_state_code == 4'h7);
  endproperty
  property p_disabled;
    (o_state_code <= 4'h2 || o_state_code == 4'h7) |-> (!o_motion_en && !o_setpoint_en);
  endproperty
  a_init: assert property (p_init) else $error("init did not end");
  a_shutdown: assert property (p_shutdown) else $error("no ready");
  a_switch_on: assert property (p_switch_on) else $error("no switch on");
  a_enable_op: assert property (p_enable_op) else $error("bad op entry");
  a_qstop: assert property (p_qstop) else $error("no quick stop");
  a_fault_entry: assert property (p_fault_entry) else $error("no reaction");
  a_fault_off: assert property (p_fault_off) else $error("power kept");
  a_hold_fault: assert property (p_hold_fault) else $error("left fault");
  a_disabled: assert property (p_disabled) else $error("motion on");
endmodule
bind dps_state_machine dps_sm_monitor u_dps_sm_monitor (.i_clk(i_clk), .i_rst(i_rst),
  .i_cmd(i_cmd), .i_enable_in(i_enable_in), .i_err_set(i_err_set),
  .i_err_active(i_err_active), .i_fatal(i_fatal), .o_state_code(o_state_code),
  .o_power_en(o_power_en), .o_motion_en(o_motion_en), .o_setpoint_en(o_setpoint_en),
  .o_setpoint_clr(o_setpoint_clr), .o_err_flags(o_err_flags));

//--- bench/tb_dps_state_machine.sv
`timescale 1ns/1ps
// ************************************
// Power state machine bench
// ************************************
module tb_dps_state_machine;
  reg i_clk = 1'b0;
  reg i_rst = 1'b1;
  reg [15:0] req = 16'h0000;
  reg i_enable_in = 1'b0;
  reg [7:0] i_err_set = 8'h00;
  reg [7:0] i_err_active = 8'h00;
  reg i_fatal = 1'b0;
  reg [2:0] i_qstop_opt = 3'h1;
  reg i_stop_done = 1'b0;
  reg i_react_done = 1'b0;
  reg i_cfg_dis_ramp = 1'b1;
  reg i_brake_applied = 1'b0;
  reg [2:0] bit_sel = 3'h0;
  reg [3:0] last = 4'h0;
  reg [3:0] exp_q [$];
  integer seed = 68494;
  integer n_mismatch = 0;
  integer n_compared = 0;
  integer k;
  wire [15:0] cmd;
  wire [3:0] code;
  wire [7:0] flags;
  wire power_en, motion_en, setpoint_clr, ramp_stop, comm;
  wire zero_torque, setpoint_en, quick_stop, fault_react, motor_free, mains_on;
  always #5 i_clk = ~i_clk;
  dps_master_model u_dps_master_model (.i_clk(i_clk), .i_req_cmd(req), .i_state_code(code),
    .o_cmd(cmd));
  dps_state_machine #(.INIT_CYC(8'h02)) u_dps_state_machine (.i_clk(i_clk), .i_rst(i_rst),
    .i_cmd(cmd), .i_enable_in(i_enable_in), .i_err_set(i_err_set), .i_fatal(i_fatal),
    .i_err_active(i_err_active), .i_qstop_opt(i_qstop_opt), .i_cfg_fault_ramp(1'b1),
    .i_cfg_dis_ramp(i_cfg_dis_ramp), .i_mains_ctrl(1'b1), .i_brake_applied(i_brake_applied),
    .i_stop_done(i_stop_done), .i_fault_react_done(i_react_done), .o_state_code(code),
    .o_comm_active(comm), .o_power_en(power_en), .o_mains_on(mains_on),
    .o_zero_torque(zero_torque), .o_motion_en(motion_en), .o_setpoint_en(setpoint_en),
    .o_setpoint_clr(setpoint_clr), .o_ramp_stop(ramp_stop), .o_quick_stop(quick_stop),
    .o_fault_react(fault_react), .o_motor_free(motor_free),
    .o_err_flags(flags));
  task chk(input [7:0] seen, input [7:0] want);
  begin
    n_compared = n_compared + 1;
    if (seen !== want)
    begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  end
  endtask
  task final_report;
  begin
    if (n_mismatch == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  // Note the state to reach, then wait for it within a bound
  task await(input [3:0] s);
    integer t;
  begin
    exp_q.push_back(s);
    for (t = 0; t < 40 && code !== s; t = t + 1)
    begin
      @(posedge i_clk);
      #1;
    end
    if (code !== s)
    begin
      n_mismatch = n_mismatch + 1;
      final_report;
    end
  end
  endtask
  task drive(input [15:0] c);
    reg [15:0] r;
  begin
    r = $random(seed);
    @(posedge i_clk);
    req <= {r[15:8], c[7:0]};
  end
  endtask
  task step(input [15:0] c, input [3:0] s);
  begin
    drive(c);
    await(s);
  end
  endtask
  // Compare each state change against the oldest note
  always @(posedge i_clk)
  begin
    if (!i_rst && code !== last)
      chk({4'h0, code}, (exp_q.size() == 0) ? 8'hff : {4'h0, exp_q.pop_front()});
    last <= code;
  end
  // Main sequence
  initial
  begin
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    await(4'h1);
    chk({7'h00, comm}, 8'h01);
    step(16'h0006, 4'h2);
    drive(16'h0007);
    repeat (4) @(posedge i_clk);
    #1;
    chk({4'h0, code}, 8'h02);
    @(posedge i_clk);
    i_enable_in <= 1'b1;
    step(16'h0007, 4'h3);
    chk({4'h0, power_en, zero_torque, mains_on, motor_free}, 8'h0e);
    step(16'h000f, 4'h4);
    chk({4'h0, zero_torque, setpoint_en, setpoint_clr, motion_en}, 8'h07);
    drive(16'h0007);
    repeat (3) @(posedge i_clk);
    #1;
    chk({2'b00, ramp_stop, motion_en, code}, 8'h24);
    @(posedge i_clk);
    i_stop_done <= 1'b1;
    await(4'h3);
    @(posedge i_clk);
    i_stop_done <= 1'b0;
    i_cfg_dis_ramp <= 1'b0;
    step(16'h000f, 4'h4);
    step(16'h0007, 4'h3);
    @(posedge i_clk);
    i_cfg_dis_ramp <= 1'b1;
    step(16'h0006, 4'h2);
    chk({5'h00, power_en, mains_on, motor_free}, 8'h01);
    step(16'h0000, 4'h1);
    @(posedge i_clk);
    i_brake_applied <= 1'b1;
    repeat (4) @(posedge i_clk);
    #1;
    chk({7'h00, motor_free}, 8'h00);
    @(posedge i_clk);
    i_brake_applied <= 1'b0;
    for (k = 1; k <= 8; k = k + 1)
    begin
      @(posedge i_clk);
      i_qstop_opt <= k[2:0];
      if (code === 4'h1)
      begin
        step(16'h0006, 4'h2);
        step(16'h0007, 4'h3);
        step(16'h000f, 4'h4);
      end
      step(16'h000b, 4'h5);
      chk({6'h00, quick_stop, power_en}, 8'h03);
      if (k <= 4)
      begin
        @(posedge i_clk);
        i_stop_done <= 1'b1;
        await(4'h1);
        @(posedge i_clk);
        i_stop_done <= 1'b0;
      end
      else
        step(16'h000f, 4'h4);
    end
    @(posedge i_clk);
    i_fatal <= 1'b1;
    await(4'h7);
    @(posedge i_clk);
    i_fatal <= 1'b0;
    step(16'h0080, 4'h1);
    bit_sel = $random(seed);
    @(posedge i_clk);
    i_err_set <= 8'h01 << bit_sel;
    i_err_active <= 8'h01 << bit_sel;
    req <= 16'h0000;
    await(4'h6);
    chk({6'h00, fault_react, power_en}, 8'h03);
    @(posedge i_clk);
    i_react_done <= 1'b1;
    i_err_set <= 8'h00;
    await(4'h7);
    chk({5'h00, power_en, motion_en, zero_torque}, 8'h01);
    chk(flags, 8'h01 << bit_sel);
    @(posedge i_clk);
    i_react_done <= 1'b0;
    drive(16'h0080);
    repeat (4) @(posedge i_clk);
    #1;
    chk({4'h0, code}, 8'h07);
    @(posedge i_clk);
    i_err_active <= 8'h00;
    repeat (4) @(posedge i_clk);
    #1;
    chk({4'h0, code}, 8'h07);
    @(posedge i_clk);
    req <= 16'h0000;
    step(16'h0080, 4'h1);
    repeat (2) @(posedge i_clk);
    #1;
    chk(flags, 8'h00);
    chk({7'h00, cmd[7]}, 8'h00);
    final_report;
  end
endmodule

//--- logic/dps_err_mem.v
`timescale 1ns/1ps
// ************************************************************
// Motion error flag store
// ************************************************************
module dps_err_mem #(
  parameter W = 8
) (
  input wire i_clk,
  input wire i_rst,
  input wire [W-1:0] i_set,
  input wire [W-1:0] i_active,
  input wire i_clear,
  output reg [W-1:0] o_flags
);

  // Set wins over clear; clear drops only flags whose cause is gone
  always @(posedge i_clk)
  begin
    if (i_rst)
      o_flags <= {W{1'b0}};
    else if (i_clear)
      o_flags <= i_set | (o_flags & i_active);
    else
      o_flags <= o_flags | i_set;
  end

endmodule

//--- logic/dps_regs.vh
`ifndef DPS_REGS_VH
`define DPS_REGS_VH
// Command word bit positions
`define DPS_CMD_SWITCH_ON 0
`define DPS_CMD_EN_VOLT 1
`define DPS_CMD_QSTOP_N 2
`define DPS_CMD_EN_OP 3
`define DPS_CMD_FAULT_RST 7
`define DPS_CMD_W 16
// State codes reported to the master
`define DPS_CODE_W 4
`define DPS_CODE_NOT_READY 4'h0
`define DPS_CODE_SO_DIS 4'h1
`define DPS_CODE_READY 4'h2
`define DPS_CODE_SW_ON 4'h3
`define DPS_CODE_OP_EN 4'h4
`define DPS_CODE_QSTOP 4'h5
`define DPS_CODE_FR_ACT 4'h6
`define DPS_CODE_FAULT 4'h7
// Quick-stop option code range limits
`define DPS_QSO_W 3
`define DPS_QSO_LO_MIN 3'h1
`define DPS_QSO_LO_MAX 3'h4
`define DPS_QSO_HI_MIN 3'h5
// Option code 5..8 is held as 3 bits: value minus one is not used; 8 wraps to 0
`define DPS_QSO_EIGHT 3'h0
// Error flag count
`define DPS_ERR_W 8
// Initialisation length in cycles
`define DPS_INIT_CYC 8'h10
`define DPS_INIT_W 8
`endif

//--- logic/dps_state_machine.v
`timescale 1ns/1ps
`include "dps_regs.vh"
// Contract
// (R1) Reset: self-init, then switch-on-disabled, comms on
// (R2) Shutdown command enters ready-to-switch-on, no action
// (R3) Switch-on enables power if enable input active
// (R4) Enable operation: motion on, set-points cleared
// (R5) Clear bit3: ramp stop, then switched-on
// (R6) Clear bit0: power off, ready-to-switch-on
// (R7) Clear bit1/2: switch-on-disabled, power off
// (R8) Clear bit2 in operation: quick-stop, power kept
// (R9) Quick-stop option 1-4: disable after stop
// (R10) Option 5-8: enable operation returns to operation
// (R11) Any fault enters fault-reaction-active state; here fatal goes straight to fault and not-ready ignores faults
// (R12) Reaction done: fault state, power off
// (R13) Fault reset clears errors whose cause gone
// (R14) Leave fault only when all errors cleared
// (R15) Master clears fault-reset bit after fault exit
// (R16) Finish associated action before changing state
// (R17) Drive disabled: no energy, set-points ignored
// (R18) Drive enabled: energise, process set-points
// (R19) Fatal error switches off immediately
// (R20) Configuration selects disable, stop, halt, fault behaviour; there is no halt option here
// (R21) Mains off: motor free unless braked
// (R22) Fault reset acts on rising edge only
// (R23) Current state exposed as distinct code
module dps_state_machine #(
  parameter ERR_W = `DPS_ERR_W,
  parameter INIT_CYC = `DPS_INIT_CYC
) (
  input wire i_clk,
  input wire i_rst,
  input wire [`DPS_CMD_W-1:0] i_cmd,
  input wire i_enable_in,
  input wire [ERR_W-1:0] i_err_set,
  input wire [ERR_W-1:0] i_err_active,
  input wire i_fatal,
  input wire [`DPS_QSO_W-1:0] i_qstop_opt,
  input wire i_cfg_fault_ramp,
  input wire i_cfg_dis_ramp,
  input wire i_mains_ctrl,
  input wire i_brake_applied,
  input wire i_stop_done,
  input wire i_fault_react_done,
  output reg [`DPS_CODE_W-1:0] o_state_code,
  output reg o_comm_active,
  output reg o_power_en,
  output reg o_mains_on,
  output reg o_zero_torque,
  output reg o_motion_en,
  output reg o_setpoint_en,
  output reg o_setpoint_clr,
  output reg o_ramp_stop,
  output reg o_quick_stop,
  output reg o_fault_react,
  output reg o_motor_free,
  output reg [ERR_W-1:0] o_err_flags
);

  // ************************************************************
  // State encoding
  // ************************************************************
  localparam [7:0] ST_NRDY = 8'h01;
  localparam [7:0] ST_SODIS = 8'h02;
  localparam [7:0] ST_READY = 8'h04;
  localparam [7:0] ST_SWON = 8'h08;
  localparam [7:0] ST_OPEN = 8'h10;
  localparam [7:0] ST_QSTOP = 8'h20;
  localparam [7:0] ST_FRACT = 8'h40;
  localparam [7:0] ST_FAULT = 8'h80;

  reg [7:0] state_reg;
  reg [7:0] state_next;
  reg [`DPS_INIT_W-1:0] init_cnt_reg;
  reg fr_prev_reg;
  reg dis_pend_reg;
  reg dis_pend_next;
  reg enable_meta_reg;
  reg enable_sync_reg;
  reg brake_meta_reg;
  reg brake_sync_reg;
  wire [`DPS_CODE_W-1:0] code_next;
  wire [ERR_W-1:0] flags;
  wire sw_on;
  wire en_volt;
  wire qstop_n;
  wire en_op;
  wire fr_rise;
  wire fault_any;
  wire init_done;
  wire qso_lo;
  wire qso_hi;
  wire drive_en;
  wire pwr_on;
  wire err_clear;
  wire flags_idle;

  // ************************************************************
  // Decode functions
  // ************************************************************
  // Power stage energised; a fatal error drops it at once
  function pwr_state;
    input [7:0] st;
    input fatal;
  begin
    pwr_state = (st == ST_SWON) || (st == ST_OPEN) || (st == ST_QSTOP)
      || ((st == ST_FRACT) && !fatal); // R3 R12 R19
  end
  endfunction

  // Drive function enabled: motor may be energised
  function drive_state;
    input [7:0] st;
  begin
    drive_state = (st == ST_OPEN) || (st == ST_QSTOP);
  end
  endfunction

  // Distinct code for each state, read by the master
  function [`DPS_CODE_W-1:0] state_code;
    input [7:0] st;
  begin
    case (st)
      ST_NRDY: state_code = `DPS_CODE_NOT_READY;
      ST_SODIS: state_code = `DPS_CODE_SO_DIS;
      ST_READY: state_code = `DPS_CODE_READY;
      ST_SWON: state_code = `DPS_CODE_SW_ON;
      ST_OPEN: state_code = `DPS_CODE_OP_EN;
      ST_QSTOP: state_code = `DPS_CODE_QSTOP;
      ST_FRACT: state_code = `DPS_CODE_FR_ACT;
      ST_FAULT: state_code = `DPS_CODE_FAULT;
      default: state_code = `DPS_CODE_NOT_READY;
    endcase
  end
  endfunction

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  // Enable and brake come from pins: two flops before any logic reads them
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      enable_meta_reg <= 1'b0;
      enable_sync_reg <= 1'b0;
      brake_meta_reg <= 1'b0;
      brake_sync_reg <= 1'b0;
    end
    else
    begin
      enable_meta_reg <= i_enable_in;
      enable_sync_reg <= enable_meta_reg;
      brake_meta_reg <= i_brake_applied;
      brake_sync_reg <= brake_meta_reg;
    end
  end

  // ************************************************************
  // Command decode
  // ************************************************************
  assign sw_on = i_cmd[`DPS_CMD_SWITCH_ON];
  assign en_volt = i_cmd[`DPS_CMD_EN_VOLT];
  assign qstop_n = i_cmd[`DPS_CMD_QSTOP_N];
  assign en_op = i_cmd[`DPS_CMD_EN_OP];
  assign fr_rise = i_cmd[`DPS_CMD_FAULT_RST] & ~fr_prev_reg; // R22
  assign fault_any = |i_err_set;
  assign init_done = (init_cnt_reg == INIT_CYC[`DPS_INIT_W-1:0]);
  // Option 1..4 versus 5..8 (8 held as zero)
  assign qso_lo = (i_qstop_opt >= `DPS_QSO_LO_MIN) && (i_qstop_opt <= `DPS_QSO_LO_MAX); // R20
  assign qso_hi = (i_qstop_opt >= `DPS_QSO_HI_MIN) || (i_qstop_opt == `DPS_QSO_EIGHT);
  assign err_clear = (state_reg == ST_FAULT) && fr_rise; // R13
  // Fault may be left only when no held flag is still active
  assign flags_idle = ((flags & i_err_active) == {ERR_W{1'b0}}) && !fault_any; // R14

  // ************************************************************
  // Error flags
  // ************************************************************
  dps_err_mem #(
    .W(ERR_W)
  ) u_err (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_set(i_err_set),
    .i_active(i_err_active),
    .i_clear(err_clear),
    .o_flags(flags)
  );

  // ************************************************************
  // Initialisation and edge history
  // ************************************************************
  // Init counter and fault-reset edge history
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      init_cnt_reg <= {`DPS_INIT_W{1'b0}};
      fr_prev_reg <= 1'b0;
    end
    else
    begin
      fr_prev_reg <= i_cmd[`DPS_CMD_FAULT_RST];
      if (state_reg == ST_NRDY && !init_done)
        init_cnt_reg <= init_cnt_reg + 1'b1; // R1
    end
  end

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always @*
  begin
    state_next = state_reg;
    dis_pend_next = dis_pend_reg;
    case (state_reg)
      ST_NRDY:
      begin
        if (init_done)
          state_next = ST_SODIS; // R1
      end
      ST_SODIS:
      begin
        if (en_volt && qstop_n)
          state_next = ST_READY; // R2
      end
      ST_READY:
      begin
        if (!en_volt || !qstop_n)
          state_next = ST_SODIS; // R7
        else if (sw_on && enable_sync_reg)
          state_next = ST_SWON; // R3
      end
      ST_SWON:
      begin
        if (!en_volt || !qstop_n)
          state_next = ST_SODIS; // R7
        else if (!sw_on)
          state_next = ST_READY; // R6
        else if (en_op)
          state_next = ST_OPEN; // R4
      end
      ST_OPEN:
      begin
        if (!en_volt)
          state_next = ST_SODIS; // R7
        else if (!qstop_n)
          state_next = ST_QSTOP; // R8
        else if (!sw_on)
          state_next = ST_READY; // R6
        else if (!en_op)
        begin
          // Stay until the ramp stop finishes
          if (!i_cfg_dis_ramp || i_stop_done)
            state_next = ST_SWON; // R5 R16
        end
      end
      ST_QSTOP:
      begin
        if (!en_volt)
          dis_pend_next = 1'b1; // R9
        if (qso_lo && i_stop_done)
          state_next = ST_SODIS; // R9 R16
        else if ((dis_pend_reg || !en_volt) && (qso_lo || i_stop_done))
          state_next = ST_SODIS; // R9
        else if (qso_hi && qstop_n && en_op && en_volt)
          state_next = ST_OPEN; // R10
        if (state_next != ST_QSTOP)
          dis_pend_next = 1'b0;
      end
      ST_FRACT:
      begin
        if (i_fault_react_done || !i_cfg_fault_ramp)
          state_next = ST_FAULT; // R12
      end
      ST_FAULT:
      begin
        if (fr_rise && flags_idle)
          state_next = ST_SODIS; // R14
      end
      default:
        state_next = ST_NRDY;
    endcase
    // Fault overrides every state except not-ready and fault; fatal skips the reaction
    if (state_reg != ST_NRDY && state_reg != ST_FAULT)
    begin
      if (i_fatal)
        state_next = ST_FAULT; // R19
      else if (fault_any && state_reg != ST_FRACT)
        state_next = ST_FRACT; // R11
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Power and drive enable for the state being entered
  assign pwr_on = pwr_state(state_next, i_fatal);
  assign drive_en = drive_state(state_next); // R17 R18

  // State code for the next state
  assign code_next = state_code(state_next); // R23

  // State register and pending disable request
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state_reg <= ST_NRDY;
      dis_pend_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      dis_pend_reg <= dis_pend_next;
    end
  end

  // Registered outputs, taken from the state being entered; error flags copied from the store
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_state_code <= `DPS_CODE_NOT_READY;
      o_comm_active <= 1'b0;
      o_power_en <= 1'b0;
      o_mains_on <= 1'b0;
      o_zero_torque <= 1'b1;
      o_motion_en <= 1'b0;
      o_setpoint_en <= 1'b0;
      o_setpoint_clr <= 1'b0;
      o_ramp_stop <= 1'b0;
      o_quick_stop <= 1'b0;
      o_fault_react <= 1'b0;
      o_motor_free <= 1'b1;
      o_err_flags <= {ERR_W{1'b0}};
    end
    else
    begin
      o_state_code <= code_next; // R23
      o_comm_active <= (state_next != ST_NRDY); // R1
      o_power_en <= pwr_on; // R3 R6 R7 R12
      o_mains_on <= pwr_on || !i_mains_ctrl; // R21
      o_zero_torque <= !drive_en; // R3 R17
      o_motion_en <= (state_next == ST_OPEN) && !((state_reg == ST_OPEN) && !en_op); // R5
      o_setpoint_en <= drive_en && (state_next == ST_OPEN); // R18
      o_setpoint_clr <= (state_reg == ST_SWON) && (state_next == ST_OPEN); // R4
      o_ramp_stop <= (state_next == ST_OPEN) && !en_op; // R5
      o_quick_stop <= (state_next == ST_QSTOP); // R8
      o_fault_react <= (state_next == ST_FRACT); // R11
      o_motor_free <= !pwr_on && !brake_sync_reg; // R21
      o_err_flags <= flags;
    end
  end

endmodule
